/* File: rtl/waveform_playback_issue_unit.sv */
`timescale 1ns/1ns
// Overview of operation
// - immediate segment play starts at once, aborting any playback underway
// - segment play outputs length samples starting offset samples in
// - explicit output mask routes each waveform to its own channel, on segment play only; other ops ignore it
// - empty output mask assigns channels by number of waveforms supplied
// - four-channel play runs with four-channel mode and preset routing masked to the lowest channels, one per waveform supplied
// - four-channel play waits queued until the previous playback ends
// - silence play drives zero on all channels for exactly count samples
// - silence play behaves as queued play but never reads memory
// - given rate is used, otherwise the configured default rate
// - the block steps once per mclk cycle of 100 ns, not once per 4.44 ns sequencer clock cycle
module waveform_playback_issue_unit
  import playback_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS,
  parameter int SW = SAMPLE_WIDTH
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire playback_pkg::op_e instr_op,
  input wire logic [NCH-1:0] instr_outputs,
  input wire logic [2:0] instr_wave_count,
  input wire logic [playback_pkg::ADDR_WIDTH-1:0] instr_base,
  input wire logic [playback_pkg::ADDR_WIDTH-1:0] instr_offset,
  input wire logic [playback_pkg::LEN_WIDTH-1:0] instr_length,
  input wire logic instr_rate_given,
  input wire logic [playback_pkg::RATE_WIDTH-1:0] instr_rate,
  input wire logic default_rate_write,
  input wire logic [playback_pkg::RATE_WIDTH-1:0] default_rate_value,
  input wire logic [NCH-1:0] four_channel_routing,
  output logic mem_read,
  output logic [playback_pkg::ADDR_WIDTH-1:0] mem_addr,
  input wire logic [NCH*SW-1:0] mem_data,
  output logic [NCH*SW-1:0] sample_out,
  output logic [NCH-1:0] channel_active,
  output logic sample_strobe,
  output logic four_channel_mode,
  output logic busy
);
  typedef enum logic [1:0] {IDLE, PLAY, WAIT_DATA} state_e;

  state_e state;
  state_e next_state;
  logic [RATE_WIDTH-1:0] default_sample_rate_setting;
  logic [RATE_WIDTH-1:0] next_default_sample_rate_setting;
  logic [RATE_WIDTH-1:0] rate;
  logic [RATE_WIDTH-1:0] next_rate;
  logic [ADDR_WIDTH-1:0] addr;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [LEN_WIDTH-1:0] remaining;
  logic [LEN_WIDTH-1:0] next_remaining;
  logic [NCH-1:0] route;
  logic [NCH-1:0] next_route;
  logic silent;
  logic next_silent;
  logic four_mode;
  logic next_four_mode;
  logic [NCH*SW-1:0] next_sample_out;
  logic next_strobe;
  logic [NCH-1:0] auto_route;
  logic start;
  logic restart;
  logic tick;
  logic last;

  rate_divider #(.RW(RATE_WIDTH)) u_div (
    .mclk(mclk),
    .reset(reset),
    .restart(restart),
    .rate(rate),
    .tick(tick)
  );

  // lowest channels filled first, one per waveform
  always_comb
  begin
    auto_route = '0;
    for (int i = 0; i < NCH; i++)
    begin
      if (3'(i) < instr_wave_count)
      begin
        auto_route[i] = 1'b1;
      end
    end
  end

  assign last = (remaining == 16'h0001);
  // queued ops only pass once playback is idle or on its final sample
  always_comb
  begin
    if (instr_op == OP_SEGMENT_NOW)
    begin
      instr_ready = 1'b1;
    end
    else
    begin
      instr_ready = (state == IDLE) || (state == PLAY && last && tick);
    end
  end
  assign start = instr_valid && instr_ready;
  assign restart = start;

  always_comb
  begin
    next_state = state;
    next_default_sample_rate_setting = default_sample_rate_setting;
    next_rate = rate;
    next_addr = addr;
    next_remaining = remaining;
    next_route = route;
    next_silent = silent;
    next_four_mode = four_mode;
    next_sample_out = sample_out;
    next_strobe = 1'b0;
    mem_read = 1'b0;
    mem_addr = addr;
    if (default_rate_write)
    begin
      next_default_sample_rate_setting = default_rate_value;
    end
    if (state == PLAY && tick)
    begin
      next_strobe = 1'b1;
      // memory word arrives with the strobe; silence never touches memory
      if (silent)
      begin
        next_sample_out = '0;
      end
      else
      begin
        mem_read = 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
          next_sample_out[c*SW +: SW] = route[c] ?
            mem_data[c*SW +: SW] : '0;
        end
        next_addr = addr + 16'h0001;
      end
      next_remaining = remaining - 16'h0001;
      if (last)
      begin
        next_state = IDLE;
        next_four_mode = 1'b0;
      end
    end
    if (start)
    begin
      next_state = PLAY;
      next_rate = instr_rate_given ? instr_rate :
        default_sample_rate_setting;
      next_remaining = instr_length;
      next_silent = (instr_op == OP_SILENCE);
      next_four_mode = (instr_op == OP_FOUR_CHANNEL);
      case (instr_op)
        OP_SEGMENT_NOW:
        begin
          next_addr = instr_base + instr_offset;
          next_route = (instr_outputs != '0) ? instr_outputs : auto_route;
        end
        OP_FOUR_CHANNEL:
        begin
          next_addr = instr_base;
          next_route = auto_route & four_channel_routing;
        end
        OP_SILENCE:
        begin
          next_addr = '0;
          next_route = '1;
        end
        default:
        begin
          next_addr = instr_base;
          next_route = auto_route;
        end
      endcase
      if (instr_length == '0)
      begin
        next_state = IDLE;
      end
    end
  end

  // one state step per mclk edge; this 100 ns clock is slower than the 4.44 ns sequencer cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= IDLE;
      default_sample_rate_setting <= RESET_DEFAULT_RATE;
      rate <= RESET_DEFAULT_RATE;
      addr <= '0;
      remaining <= '0;
      route <= '0;
      silent <= 1'b0;
      four_mode <= 1'b0;
      sample_out <= '0;
      sample_strobe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      default_sample_rate_setting <= next_default_sample_rate_setting;
      rate <= next_rate;
      addr <= next_addr;
      remaining <= next_remaining;
      route <= next_route;
      silent <= next_silent;
      four_mode <= next_four_mode;
      sample_out <= next_sample_out;
      sample_strobe <= next_strobe;
    end
  end

  assign channel_active = (state == PLAY) ? route : '0;
  assign four_channel_mode = four_mode;
  assign busy = (state != IDLE);
endmodule

/* File: rtl/playback_pkg.sv */
package playback_pkg;
  localparam int NUM_CHANNELS = 4;
  localparam int SAMPLE_WIDTH = 16;
  localparam int ADDR_WIDTH = 16;
  localparam int LEN_WIDTH = 16;
  localparam int RATE_WIDTH = 4;
  // sequencer cycle period, in picoseconds (4.44 ns)
  localparam int SEQ_CYCLE_PS = 4440;
  // mclk period in picoseconds; one sequencer step per mclk edge
  localparam int MCLK_PERIOD_PS = 100000;
  localparam int SEQ_STEP_CYCLES = (SEQ_CYCLE_PS + MCLK_PERIOD_PS - 1)
    / MCLK_PERIOD_PS;
  localparam logic [RATE_WIDTH-1:0] RESET_DEFAULT_RATE = 4'h0;
  localparam int MIN_LENGTH = 32;
  localparam int LENGTH_GRAIN = 16;
  localparam logic [ADDR_WIDTH-1:0] WAVE_BASE_STRIDE = 16'h0100;
  typedef enum logic [1:0] {
    OP_SEGMENT_NOW,
    OP_FOUR_CHANNEL,
    OP_SILENCE,
    OP_WAVE_QUEUED
  } op_e;
endpackage

/* File: rtl/rate_divider.sv */
`timescale 1ns/1ns
// turns a rate exponent into a sample strobe: one sample per 2**rate cycles
module rate_divider
  import playback_pkg::*;
#(
  parameter int RW = RATE_WIDTH
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic restart,
  input wire logic [RW-1:0] rate,
  output logic tick
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic [15:0] limit;

  always_comb
  begin
    limit = (16'h0001 << rate) - 16'h0001;
    next_count = count + 16'h0001;
    tick = (count >= limit);
    // restart only rewinds the count: tick must not depend on it, since
    // the issue logic feeds tick back into restart through instr_ready
    if (restart || tick)
    begin
      next_count = 16'h0000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count <= 16'h0000;
    end
    else
    begin
      count <= next_count;
    end
  end
endmodule

/* File: tb/waveform_playback_issue_unit_checker.sv */
`timescale 1ns/1ns
module waveform_playback_issue_unit_checker
  import playback_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS,
  parameter int SW = SAMPLE_WIDTH
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire playback_pkg::op_e instr_op,
  input wire logic [NCH-1:0] instr_outputs,
  input wire logic [2:0] instr_wave_count,
  input wire logic [ADDR_WIDTH-1:0] instr_base,
  input wire logic [ADDR_WIDTH-1:0] instr_offset,
  input wire logic [LEN_WIDTH-1:0] instr_length,
  input wire logic instr_rate_given,
  input wire logic [RATE_WIDTH-1:0] instr_rate,
  input wire logic [NCH-1:0] four_channel_routing,
  input wire logic mem_read,
  input wire logic [ADDR_WIDTH-1:0] mem_addr,
  input wire logic [NCH*SW-1:0] sample_out,
  input wire logic [NCH-1:0] channel_active,
  input wire logic sample_strobe,
  input wire logic four_channel_mode
);
  logic take, fast;
  logic [NCH*SW-1:0] lanes;
  // length above one so the route is still up two cycles later
  always_comb
  begin
    take = instr_valid && instr_ready && instr_length > 16'h0001;
    fast = instr_rate_given && instr_rate == 4'h0;
    for (int c = 0; c < NCH; c++)
      lanes[c*SW +: SW] = {SW{channel_active[c]}};
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_segment_no_wait:
    assert property (instr_valid && instr_op == OP_SEGMENT_NOW
      |-> instr_ready) else $error("segment op held off");
  a_segment_start_addr:
    assert property (take && fast && instr_op == OP_SEGMENT_NOW |=> mem_read
      && mem_addr == 16'($past(instr_base) + $past(instr_offset)))
    else $error("segment start address wrong");
  a_explicit_route:
    assert property (take && instr_op == OP_SEGMENT_NOW && instr_outputs != 0
      |-> ##2 channel_active == $past(instr_outputs, 2))
    else $error("explicit route wrong");
  a_auto_route:
    assert property (take && instr_op == OP_SEGMENT_NOW && instr_outputs == 0
      |-> ##2 channel_active == NCH'((1 << $past(instr_wave_count, 2)) - 1))
    else $error("auto route wrong");
  a_four_mode_route:
    assert property (take && instr_op == OP_FOUR_CHANNEL |-> ##2
      four_channel_mode && channel_active == (NCH'((1 <<
      $past(instr_wave_count, 2)) - 1) & $past(four_channel_routing, 2)))
    else $error("four-channel mode or routing wrong");
  a_unrouted_zero:
    assert property (sample_strobe |-> (sample_out & ~$past(lanes)) == '0)
    else $error("idle lane not zero");
  a_silence_no_read:
    assert property (take && instr_op == OP_SILENCE |=> !mem_read [*2])
    else $error("silence read memory");
  a_first_strobe:
    assert property (take && fast |-> ##2 sample_strobe)
    else $error("first sample late");
endmodule
bind waveform_playback_issue_unit waveform_playback_issue_unit_checker
  #(.NCH(NCH), .SW(SW)) u_chk (.mclk, .reset, .instr_valid, .instr_ready,
  .instr_op, .instr_outputs, .instr_wave_count, .instr_base, .instr_offset,
  .instr_length, .instr_rate_given, .instr_rate, .four_channel_routing,
  .mem_read, .mem_addr, .sample_out, .channel_active, .sample_strobe,
  .four_channel_mode);

/* File: tb/wave_memory_model.sv */
`timescale 1ns/1ns
module wave_memory_model
(
  input wire logic mem_read,
  input wire logic [15:0] mem_addr,
  output logic [63:0] mem_data
);
  logic [13:0] a;
  assign a = mem_addr[13:0];
  // inverted when not read, so a late capture never passes
  assign mem_data = {64{~mem_read}} ^ {2'h3, a, 2'h2, a, 2'h1, a, 2'h0, a};
endmodule

/* File: tb/waveform_playback_issue_unit_tb_top.sv */
`timescale 1ns/1ns
module waveform_playback_issue_unit_tb_top;
  import playback_pkg::*;
  logic mclk = 0, reset = 1, instr_valid = 0, instr_rate_given = 0;
  logic default_rate_write = 0, mem_read, sample_strobe, instr_ready;
  logic four_channel_mode, busy;
  op_e instr_op = OP_SILENCE;
  logic [3:0] instr_outputs = 4'h0, instr_rate = 4'h0, channel_active;
  logic [3:0] default_rate_value = 4'h0, four_channel_routing = 4'hA;
  logic [2:0] instr_wave_count = 3'h0;
  logic [15:0] instr_base = 16'h0, instr_offset = 16'h0;
  logic [15:0] instr_length = 16'h0, mem_addr;
  logic [63:0] mem_data, sample_out, s;
  int n_errors = 0, n_tests = 0, k, n, r;
  always #50 mclk = ~mclk;
  waveform_playback_issue_unit dut (.mclk, .reset, .instr_valid,
    .instr_ready, .instr_op, .instr_outputs, .instr_wave_count, .instr_base,
    .instr_offset, .instr_length, .instr_rate_given, .instr_rate,
    .default_rate_write, .default_rate_value, .four_channel_routing,
    .mem_read, .mem_addr, .mem_data, .sample_out, .channel_active,
    .sample_strobe, .four_channel_mode, .busy);
  wave_memory_model mem (.mem_read, .mem_addr, .mem_data);
  function automatic logic [63:0] ex(logic [15:0] a, logic [3:0] m);
    for (int c = 0; c < 4; c++)
      ex[c*16 +: 16] = m[c] ? {c[1:0], a[13:0]} : 16'h0;
  endfunction
  task chk(logic [63:0] got, logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task step;
    @(posedge mclk);
    #1;
  endtask
  task bail;
    n_errors++;
    close_out;
  endtask
  // held until the edge that sees ready, released one cycle on
  task issue(op_e o, logic [3:0] m, logic [2:0] w, logic [15:0] b, f, l,
    logic g);
    instr_op = o;
    instr_outputs = m;
    instr_wave_count = w;
    instr_base = b;
    instr_offset = f;
    instr_length = l;
    instr_rate_given = g;
    instr_valid = 1;
    // let ready settle on the new op before looking at it
    #1;
    for (k = 0; !instr_ready && k < 300; k++) step;
    if (k == 300) bail;
    step;
    instr_valid = 0;
  endtask
  task grab;
    step;
    for (k = 1; !sample_strobe && k < 300; k++) step;
    if (k == 300) bail;
    s = sample_out;
  endtask
  task t_queue;
    issue(OP_WAVE_QUEUED, 4'h0, 3'h3, 16'h0100, 16'h0, 16'h2, 1);
    grab;
    chk(s, ex(16'h0100, 4'h7));
    grab;
    chk(s, ex(16'h0101, 4'h7));
    chk(64'(k), 64'h1);
  endtask
  task t_seg;
    issue(OP_WAVE_QUEUED, 4'h0, 3'h4, 16'h0400, 16'h0, 16'h10, 1);
    grab;
    issue(OP_SEGMENT_NOW, 4'h5, 3'h2, 16'h0500, 16'h3, 16'h2, 1);
    grab;
    chk(s, ex(16'h0503, 4'h5));
    grab;
    chk(s, ex(16'h0504, 4'h5));
    step;
    chk(busy, 0);
  endtask
  task t_four;
    issue(OP_WAVE_QUEUED, 4'h0, 3'h1, 16'h0200, 16'h0, 16'h4, 1);
    instr_op = OP_FOUR_CHANNEL;
    step;
    chk(instr_ready, 0);
    issue(OP_FOUR_CHANNEL, 4'h0, 3'h2, 16'h0300, 16'h0, 16'h2, 1);
    chk(64'(k), 64'h2);
    grab;
    // two waveforms masked by the preset routing leave channel 1 only
    chk(s, ex(16'h0300, 4'h2));
    chk(four_channel_mode, 1);
  endtask
  task t_silence;
    n = 0;
    r = 0;
    issue(OP_SILENCE, 4'h0, 3'h0, 16'h0700, 16'h0, 16'h20, 0);
    for (int i = 0; i < 200; i++)
    begin
      step;
      n += sample_strobe;
      r += mem_read;
      if (sample_strobe) chk(sample_out, 0);
    end
    chk(64'(n), 64'h20);
    chk(64'(r), 64'h0);
  endtask
  task t_rate;
    default_rate_write = 1;
    default_rate_value = 4'h2;
    step;
    default_rate_write = 0;
    issue(OP_SEGMENT_NOW, 4'h0, 3'h2, 16'h0600, 16'h1, 16'h2, 0);
    grab;
    chk(s, ex(16'h0601, 4'h3));
    grab;
    chk(64'(k), 64'h4);
  endtask
  initial
  begin
    repeat (2) step;
    reset = 0;
    t_queue;
    t_seg;
    t_four;
    t_silence;
    t_rate;
    close_out;
  end
endmodule
